// file: verilog/mdfh_walker.sv
// descriptor list walker: flags, halt, teardown and crc choice
//
// How it works
// R01 - eop and null link: set queue-end, halt
// R02 - software clears queue-end before linking
// R03 - queue-end written only on packet-end descriptors
// R04 - teardown marks packet-start of aborted packet
// R05 - teardown touches only first unsent packet
// R06 - passthrough set: send data, no crc
// R07 - passthrough clear: append four crc bytes
// R08 - software counts crc in lengths if passthrough
// R09 - descriptor is four aligned words
// R10 - null link ends queue, never written
// R11 - software sets link before queueing
// R12 - late relink followed, else halt
// R13 - software checks queue-end to restart
// R14 - buffer pointer read, never modified
// R15 - ownership cleared on packet-start when done
// R16 - flags at bits 31..26 in word 3
// R17 - flag writes are read-modify-write of word 3
`timescale 1ns/1ps
`include "mdfh_defs.svh"
module mdfh_walker (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic start, // pulse: begin walk at head_ptr
  input wire logic [31:0] head_ptr, // first descriptor address
  input wire logic teardown, // pulse: abort queue
  output logic busy, // walker active
  output logic halted, // channel halted on end of queue
  output logic teardown_done, // pulse: teardown marked
  output logic align_err, // pulse: misaligned descriptor refused
  output logic xfer_valid, // descriptor handed to datapath
  output logic [31:0] xfer_buf, // buffer pointer
  output logic [15:0] xfer_len, // buffer length
  output logic xfer_sop, // packet start descriptor
  output logic xfer_eop, // packet end descriptor
  output logic xfer_append_crc, // datapath must append crc
  output logic [15:0] xfer_crc_bytes, // crc bytes appended
  input wire logic xfer_done, // pulse: datapath finished buffer
  mdfh_mem_if.walker mi
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    mdfh_pkg::mdfh_state_t st; // walker state
    logic [31:0] cur; // current descriptor
    logic [31:0] sop_addr; // packet start descriptor
    logic [31:0] nxt; // link as read
    logic [31:0] bufp; // buffer pointer
    logic [31:0] w3; // flags/length word
    logic [31:0] sop_w3; // word 3 of packet start descriptor as read
    logic [1:0] widx; // word being read
    logic pcrc; // passthrough of current packet
    logic tdn; // teardown pending
    logic tdn_pulse; // teardown done pulse
    logic aerr; // alignment error pulse
    logic sop_wr_done; // ownership written flag, cleared on each packet start and never set
  } mdfh_walk_t;
  mdfh_walk_t q, next_q;
  // word address inside a descriptor, used for every fetch
  function automatic logic [31:0] mdfh_waddr(input logic [31:0] base, input logic [1:0] idx);
    mdfh_waddr = base + ({30'h0000_0000, idx} * `MDFH_WORD_BYTES); // see R09
  endfunction : mdfh_waddr
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_q = q;
    next_q.tdn_pulse = 1'b0;
    next_q.aerr = 1'b0;
    case (q.st)
      mdfh_pkg::MDFH_IDLE, mdfh_pkg::MDFH_HALT: begin
        if (start) begin
          if ((head_ptr & `MDFH_ALIGN_MASK) != `MDFH_NULL) begin
            next_q.aerr = 1'b1; // see R09
          end else if (head_ptr != `MDFH_NULL) begin
            next_q.cur = head_ptr;
            next_q.widx = `MDFH_W_NEXT;
            next_q.st = mdfh_pkg::MDFH_RDNXT;
          end
        end
      end
      // read words 0..2; pointers are only read
      mdfh_pkg::MDFH_RDNXT: begin
        if (mi.ack) begin
          case (q.widx)
            `MDFH_W_NEXT: next_q.nxt = mi.rdata; // see R10
            `MDFH_W_BUF: next_q.bufp = mi.rdata; // see R14
            default: next_q.w3 = mi.rdata;
          endcase
          next_q.widx = q.widx + 2'h1;
          if (q.widx == `MDFH_W_OFFLEN) begin
            next_q.st = mdfh_pkg::MDFH_RDFLG;
          end
        end
      end
      mdfh_pkg::MDFH_RDFLG: begin
        if (mi.ack) begin
          // flags and length of this descriptor
          next_q.w3 = mi.rdata;
          next_q.bufp = q.bufp;
          if (mi.rdata[`MDFH_B_SOP]) begin // see R16
            next_q.sop_addr = q.cur;
            next_q.sop_w3 = mi.rdata; // see R17
            next_q.pcrc = mi.rdata[`MDFH_B_PCRC]; // see R06
            next_q.sop_wr_done = 1'b0;
          end
          if (q.tdn && mi.rdata[`MDFH_B_SOP]) begin
            next_q.st = mdfh_pkg::MDFH_WRSOP; // see R04
          end else begin
            next_q.st = mdfh_pkg::MDFH_XFER;
          end
        end
      end
      mdfh_pkg::MDFH_XFER: begin
        if (xfer_done) begin
          if (q.w3[`MDFH_B_EOP]) begin
            next_q.st = mdfh_pkg::MDFH_WREND; // see R15
          end else begin
            next_q.cur = q.nxt;
            next_q.widx = `MDFH_W_NEXT;
            next_q.st = mdfh_pkg::MDFH_RDNXT;
          end
        end
      end
      // end of packet: write queue-end into eop word, then ownership
      mdfh_pkg::MDFH_WREND: begin
        if (mi.ack) begin
          next_q.st = mdfh_pkg::MDFH_WRSOP;
        end
      end
      mdfh_pkg::MDFH_WRSOP: begin
        if (mi.ack) begin
          if (q.tdn) begin
            next_q.tdn = 1'b0; // see R05
            next_q.tdn_pulse = 1'b1;
            next_q.st = mdfh_pkg::MDFH_IDLE;
          end else if (q.nxt == `MDFH_NULL) begin
            next_q.st = mdfh_pkg::MDFH_HALT; // see R01
          end else begin
            next_q.cur = q.nxt; // see R12
            next_q.widx = `MDFH_W_NEXT;
            next_q.st = mdfh_pkg::MDFH_RDNXT;
          end
        end
      end
      default: next_q.st = mdfh_pkg::MDFH_IDLE;
    endcase
    // set wins: a request arriving as the last one is marked stays pending
    if (teardown) begin
      next_q.tdn = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
      q.st <= mdfh_pkg::MDFH_IDLE;
    end else begin
      q <= next_q;
    end
  end
  // ----------------------------------------
  // memory requests
  // ----------------------------------------
  // write words keep length and other flags; only target bits change
  logic [31:0] eop_word; // word 3 of eop descriptor with queue-end
  logic [31:0] sop_word; // word 3 value for sop descriptor
  always_comb begin
    eop_word = q.w3;
    eop_word[`MDFH_B_EOQ] = q.w3[`MDFH_B_EOP] & (q.nxt == `MDFH_NULL); // see R03
    // start word as read keeps its own length and flags, also for multi-fragment packets
    sop_word = q.sop_w3; // see R17
    sop_word[`MDFH_B_OWN] = 1'b0; // see R15
    if (q.tdn) begin
      sop_word[`MDFH_B_TDN] = 1'b1; // see R04
    end
    // single fragment: second write must not undo queue-end; an aborted packet never halts
    if (q.w3[`MDFH_B_SOP] && !q.tdn) begin
      sop_word[`MDFH_B_EOQ] = eop_word[`MDFH_B_EOQ]; // see R03
    end
  end
  assign mi.req = (q.st == mdfh_pkg::MDFH_RDNXT) || (q.st == mdfh_pkg::MDFH_RDFLG)
    || (q.st == mdfh_pkg::MDFH_WREND) || (q.st == mdfh_pkg::MDFH_WRSOP);
  assign mi.we = (q.st == mdfh_pkg::MDFH_WREND) || (q.st == mdfh_pkg::MDFH_WRSOP); // see R17
  assign mi.addr = (q.st == mdfh_pkg::MDFH_RDNXT) ? mdfh_waddr(q.cur, q.widx)
    : (q.st == mdfh_pkg::MDFH_WRSOP) ? mdfh_waddr(q.sop_addr, `MDFH_W_FLAGS)
    : mdfh_waddr(q.cur, `MDFH_W_FLAGS);
  assign mi.wdata = (q.st == mdfh_pkg::MDFH_WRSOP) ? sop_word : eop_word; // see R17
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign busy = (q.st != mdfh_pkg::MDFH_IDLE) && (q.st != mdfh_pkg::MDFH_HALT);
  assign halted = (q.st == mdfh_pkg::MDFH_HALT);
  assign teardown_done = q.tdn_pulse;
  assign align_err = q.aerr;
  assign xfer_valid = (q.st == mdfh_pkg::MDFH_XFER);
  assign xfer_buf = q.bufp;
  assign xfer_len = q.w3[15:0];
  assign xfer_sop = q.w3[`MDFH_B_SOP];
  assign xfer_eop = q.w3[`MDFH_B_EOP];
  assign xfer_append_crc = ~q.pcrc; // see R07
  assign xfer_crc_bytes = q.pcrc ? 16'h0000 : `MDFH_CRC_BYTES; // see R06
  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [31:0] rmw_ref; // word that the current write must preserve
  logic [31:0] wr_base; // descriptor that the current write targets
  assign rmw_ref = (q.st == mdfh_pkg::MDFH_WRSOP) ? q.sop_w3 : q.w3;
  assign wr_base = (q.st == mdfh_pkg::MDFH_WRSOP) ? q.sop_addr : q.cur;
  AST_HALT_NULL: assert property (@(posedge core_clk) disable iff (srst)
    (q.st == mdfh_pkg::MDFH_WRSOP && mi.ack && !q.tdn && q.nxt == `MDFH_NULL) |=> halted) // see R01
    else $error("no halt on null link");
  AST_EOQ_EOP: assert property (@(posedge core_clk) disable iff (srst)
    (mi.req && mi.we && mi.wdata[`MDFH_B_EOQ] && q.st == mdfh_pkg::MDFH_WREND) |-> mi.wdata[`MDFH_B_EOP]) // see R03
    else $error("queue-end on non-eop");
  AST_TDN_MARK: assert property (@(posedge core_clk) disable iff (srst)
    (q.st == mdfh_pkg::MDFH_WRSOP && q.tdn && mi.req) |-> mi.wdata[`MDFH_B_TDN]) // see R04
    else $error("teardown flag missing");
  AST_TDN_STOP: assert property (@(posedge core_clk) disable iff (srst)
    teardown_done |-> (q.st == mdfh_pkg::MDFH_IDLE && !mi.req)) // see R05
    else $error("walk continued after teardown");
  AST_CRC_PASS: assert property (@(posedge core_clk) disable iff (srst)
    (xfer_valid && q.pcrc) |-> (!xfer_append_crc && xfer_crc_bytes == 16'h0000)) // see R06
    else $error("crc added in passthrough");
  AST_CRC_GEN: assert property (@(posedge core_clk) disable iff (srst)
    (xfer_valid && !q.pcrc) |-> (xfer_append_crc && xfer_crc_bytes == `MDFH_CRC_BYTES)) // see R07
    else $error("crc not appended");
  AST_ALIGN: assert property (@(posedge core_clk) disable iff (srst)
    mi.req |-> (mi.addr[1:0] == 2'h0)) // see R09
    else $error("unaligned descriptor access");
  AST_NO_LINK_WR: assert property (@(posedge core_clk) disable iff (srst)
    (mi.req && mi.we) |-> (mi.addr == wr_base + `MDFH_FLAGS_OFS)) // see R10
    else $error("write outside flag word");
  AST_OWN_CLR: assert property (@(posedge core_clk) disable iff (srst)
    (q.st == mdfh_pkg::MDFH_WRSOP && mi.req) |-> (!mi.wdata[`MDFH_B_OWN] && mi.addr == q.sop_addr + `MDFH_FLAGS_OFS)) // see R15
    else $error("ownership not cleared on sop");
  AST_RMW: assert property (@(posedge core_clk) disable iff (srst)
    (mi.req && mi.we) |-> (mi.wdata[25:0] == rmw_ref[25:0] && mi.wdata[31:30] == rmw_ref[31:30])) // see R17
    else $error("write altered preserved bits");
  COV_HALT: cover property (@(posedge core_clk) disable iff (srst) $rose(halted));
  COV_TDN: cover property (@(posedge core_clk) disable iff (srst) teardown_done);
  COV_PASS: cover property (@(posedge core_clk) disable iff (srst) xfer_valid && q.pcrc);
  COV_CHAIN: cover property (@(posedge core_clk) disable iff (srst)
    (q.st == mdfh_pkg::MDFH_XFER && !q.w3[`MDFH_B_EOP] && xfer_done));
endmodule : mdfh_walker

// file: verilog/mdfh_defs.svh
// descriptor layout constants for the descriptor flag handler
`ifndef MDFH_DEFS_SVH
`define MDFH_DEFS_SVH
// ----------------------------------------
// word offsets (byte address = base + 4*index)
// ----------------------------------------
`define MDFH_W_NEXT 2'h0
`define MDFH_W_BUF 2'h1
`define MDFH_W_OFFLEN 2'h2
`define MDFH_W_FLAGS 2'h3
`define MDFH_WORD_BYTES 32'h0000_0004
`define MDFH_FLAGS_OFS 32'h0000_000C
// ----------------------------------------
// flag bit positions in word 3
// ----------------------------------------
`define MDFH_B_SOP 31
`define MDFH_B_EOP 30
`define MDFH_B_OWN 29
`define MDFH_B_EOQ 28
`define MDFH_B_TDN 27
`define MDFH_B_PCRC 26
`define MDFH_CRC_BYTES 16'h0004
`define MDFH_NULL 32'h0000_0000
`define MDFH_ALIGN_MASK 32'h0000_0003
`endif

// file: verilog/mdfh_pkg.sv
// types for the descriptor flag handler
package mdfh_pkg;
  // walker states, one-hot
  typedef enum logic [6:0] {
    MDFH_IDLE  = 7'h01,
    MDFH_RDNXT = 7'h02,
    MDFH_RDFLG = 7'h04,
    MDFH_XFER  = 7'h08,
    MDFH_WREND = 7'h10,
    MDFH_WRSOP = 7'h20,
    MDFH_HALT  = 7'h40
  } mdfh_state_t;
endpackage : mdfh_pkg

// file: verilog/mdfh_mem_if.sv
// memory master carrier between walker and port
`timescale 1ns/1ps
interface mdfh_mem_if;
  logic req; // access request
  logic we; // write when high
  logic [31:0] addr; // word aligned byte address
  logic [31:0] wdata; // write data
  logic ack; // one-cycle completion
  logic [31:0] rdata; // read data at ack
  modport walker (output req, output we, output addr, output wdata, input ack, input rdata);
  modport port (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface : mdfh_mem_if

// file: verilog/mdfh_mem_port.sv
// pass-through bus master port registering read data
`timescale 1ns/1ps
module mdfh_mem_port (
  input wire logic core_clk,
  input wire logic srst,
  mdfh_mem_if.port mi,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] rd; // captured read word
    logic ack; // delayed ack
  } mdfh_port_t;
  mdfh_port_t q, next_q;
  // capture memory answer one cycle late so walker sees registered data
  always_comb begin
    next_q = q;
    next_q.ack = mem_ack & ~q.ack;
    if (mem_ack) begin
      next_q.rd = mem_rdata;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  // request held until memory acks; walker holds req stable
  assign mem_req = mi.req & ~q.ack;
  assign mem_we = mi.we;
  assign mem_addr = mi.addr;
  assign mem_wdata = mi.wdata;
  assign mi.ack = q.ack;
  assign mi.rdata = q.rd;
endmodule : mdfh_mem_port

// file: verilog/mdfh_top.sv
// top of the descriptor flag handler: walker plus memory port
`timescale 1ns/1ps
module mdfh_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [31:0] head_ptr,
  input wire logic teardown,
  output logic busy,
  output logic halted,
  output logic teardown_done,
  output logic align_err,
  output logic xfer_valid,
  output logic [31:0] xfer_buf,
  output logic [15:0] xfer_len,
  output logic xfer_sop,
  output logic xfer_eop,
  output logic xfer_append_crc,
  output logic [15:0] xfer_crc_bytes,
  input wire logic xfer_done,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  mdfh_mem_if mi (); // walker to port carrier
  mdfh_walker u_walk (.core_clk(core_clk), .srst(srst), .start(start), .head_ptr(head_ptr),
    .teardown(teardown), .busy(busy), .halted(halted), .teardown_done(teardown_done),
    .align_err(align_err), .xfer_valid(xfer_valid), .xfer_buf(xfer_buf), .xfer_len(xfer_len),
    .xfer_sop(xfer_sop), .xfer_eop(xfer_eop), .xfer_append_crc(xfer_append_crc),
    .xfer_crc_bytes(xfer_crc_bytes), .xfer_done(xfer_done), .mi(mi.walker));
  mdfh_mem_port u_port (.core_clk(core_clk), .srst(srst), .mi(mi.port), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
endmodule : mdfh_top

// file: sim/mdfh_mem_model.sv
// system memory model answering the handler's bus master port
`timescale 1ns/1ps
module mdfh_mem_model (
  input wire logic core_clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // ----------------------------------------
  // storage and pacing
  // ----------------------------------------
  logic [31:0] mem [logic [31:0]]; // word store, bench preloads descriptors
  int unsigned slow; // most extra wait cycles, set by the bench
  int unsigned wait_n; // cycles left before answering
  logic done; // answered, waiting for the request to drop
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    slow = 0;
    wait_n = 0;
    done = 1'b0;
  end
  // answer after the falling edge; outside an answer the data lines toggle, as nothing drives them
  always @(negedge core_clk) begin
    mem_ack = 1'b0;
    mem_rdata = ~mem_rdata;
    if (!mem_req) begin
      done = 1'b0;
      wait_n = $urandom_range(slow, 0);
    end else if (!done && wait_n != 0) begin
      wait_n--;
    end else if (!done) begin
      // one ack per request; done holds until the request drops, so never ack it twice
      mem_ack = 1'b1;
      done = 1'b1;
      if (mem_we) mem[mem_addr] = mem_wdata;
      else mem_rdata = mem.exists(mem_addr) ? mem[mem_addr] : 32'h0000_0000;
    end
  end
endmodule : mdfh_mem_model

// file: sim/mdfh_top_tb.sv
// self-checking bench for the descriptor flag handler
`timescale 1ns/1ps
module mdfh_top_tb;
  // ----------------------------------------
  // signals and reference state
  // ----------------------------------------
  typedef struct {logic [31:0] b; logic [15:0] l; logic [2:0] f;} mdfh_exp_t; // buffer, length, sop/eop/crc
  localparam logic [31:0] f_own = 32'h2000_0000;
  localparam logic [31:0] f_eoq = 32'h1000_0000;
  localparam logic [31:0] f_tdn = 32'h0800_0000;
  logic core_clk, srst, start, teardown, xfer_done, mem_ack;
  logic [31:0] head_ptr, mem_rdata, mem_addr, mem_wdata, xfer_buf;
  logic busy, halted, teardown_done, align_err, xfer_valid, xfer_sop, xfer_eop, xfer_append_crc, mem_req, mem_we;
  logic [15:0] xfer_len, xfer_crc_bytes;
  int n_errors = 0;
  int tests_run = 0;
  int n_wr = 0; // descriptor writes seen
  mdfh_exp_t exq[$]; // expected hand-overs in order
  logic [31:0] ra, rb; // random word3 values
  mdfh_top i_mdfh_top (.core_clk, .srst, .start, .head_ptr, .teardown, .busy, .halted, .teardown_done,
    .align_err, .xfer_valid, .xfer_buf, .xfer_len, .xfer_sop, .xfer_eop, .xfer_append_crc, .xfer_crc_bytes,
    .xfer_done, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  mdfh_mem_model i_mdfh_mem_model (.core_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("errors=%0d compares=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // link set and queue-end cleared before the descriptor is queued
  task automatic put(input logic [31:0] a, input logic [31:0] link, input logic [31:0] w3, input bit ex,
    input bit pc);
    i_mdfh_mem_model.mem[a] = link;
    i_mdfh_mem_model.mem[a + 32'h4] = a ^ 32'h5A5A_0001;
    i_mdfh_mem_model.mem[a + 32'h8] = 32'h0000_0000;
    i_mdfh_mem_model.mem[a + 32'hC] = w3 & ~f_eoq;
    if (ex) exq.push_back('{a ^ 32'h5A5A_0001, w3[15:0], {w3[31], w3[30], ~pc}});
  endtask : put
  function automatic logic [31:0] rd(input logic [31:0] a);
    return i_mdfh_mem_model.mem[a];
  endfunction : rd
  function automatic logic sig(input int k);
    case (k)
      0: return xfer_valid;
      1: return halted;
      2: return teardown_done;
      default: return align_err;
    endcase
  endfunction : sig
  // bounded wait for a design flag, checked at the falling edge
  task automatic wait_on(input int k);
    int i;
    i = 0;
    while (i < 400 && sig(k) !== 1'b1) begin
      @(negedge core_clk);
      i++;
    end
    chk({31'h0, sig(k)}, 32'h1);
  endtask : wait_on
  task automatic go(input logic [31:0] a);
    head_ptr = a;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
  endtask : go
  // take n hand-overs, compare each against the reference queue
  task automatic serve(input int n);
    mdfh_exp_t e;
    repeat (n) begin
      wait_on(0);
      e = exq.pop_front();
      chk(xfer_buf, e.b);
      chk({13'h0, xfer_sop, xfer_eop, xfer_append_crc, xfer_len}, {13'h0, e.f, e.l});
      chk({16'h0, xfer_crc_bytes}, e.f[0] ? 32'h4 : 32'h0);
      xfer_done = 1'b1;
      @(negedge core_clk);
      xfer_done = 1'b0;
      @(negedge core_clk);
    end
  endtask : serve
  // every write must land on word 3 only
  always @(posedge core_clk) begin
    if (mem_req && mem_we && mem_ack) begin
      n_wr++;
      chk({28'h0, mem_addr[3:0]}, 32'hC);
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    ra = $urandom(37);
    srst = 1'b1;
    start = 1'b0;
    teardown = 1'b0;
    xfer_done = 1'b0;
    head_ptr = 32'h0000_0000;
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    chk({28'h0, busy, halted, xfer_valid, mem_req}, 32'h0);
    // single fragment, crc generated, prompt memory
    ra = ($urandom() & 32'h03FF_FFFF) | 32'hE000_0000;
    put(32'h0000_0100, 32'h0, ra, 1, 0);
    go(32'h0000_0100);
    serve(1);
    wait_on(1);
    chk(rd(32'h0000_010C), (ra & ~f_own) | f_eoq);
    chk(rd(32'h0000_0100), 32'h0);
    chk(rd(32'h0000_0104), 32'h0000_0100 ^ 32'h5A5A_0001);
    // two fragments with crc passed through, slow memory; lengths already hold the crc
    i_mdfh_mem_model.slow = 3;
    ra = ($urandom() & 32'h0000_FFFF) | 32'hA400_0000;
    rb = ($urandom() & 32'h0000_FFFF) | 32'h4000_0000;
    put(32'h0000_0200, 32'h0000_0300, ra, 1, 1);
    put(32'h0000_0300, 32'h0, rb, 1, 1);
    go(32'h0000_0200);
    serve(2);
    wait_on(1);
    chk(rd(32'h0000_020C), ra & ~f_own);
    chk(rd(32'h0000_030C), rb | f_eoq);
    // null link replaced before the walker reads it: the new link is followed
    ra = ($urandom() & 32'h0000_FFFF) | 32'hE000_0000;
    rb = ($urandom() & 32'h0000_FFFF) | 32'hE000_0000;
    put(32'h0000_0400, 32'h0000_0500, ra, 1, 0);
    put(32'h0000_0500, 32'h0, rb, 1, 0);
    go(32'h0000_0400);
    wait_on(0);
    put(32'h0000_0580, 32'h0, ra, 1, 0);
    i_mdfh_mem_model.mem[32'h0000_0500] = 32'h0000_0580;
    serve(3);
    wait_on(1);
    chk(rd(32'h0000_050C), rb & ~f_own);
    chk(rd(32'h0000_058C), (ra & ~f_own) | f_eoq);
    // relink after the link was read: channel stays halted until restarted
    i_mdfh_mem_model.mem[32'h0000_0580] = 32'h0000_0100;
    repeat (20) @(negedge core_clk);
    chk({30'h0, halted, mem_req}, 32'h2);
    // teardown: first unsent packet marked, nothing after it touched
    ra = ($urandom() & 32'h03FF_FFFF) | 32'hE000_0000;
    rb = ($urandom() & 32'h03FF_FFFF) | 32'hE000_0000;
    put(32'h0000_0600, 32'h0000_0700, ra, 0, 0);
    put(32'h0000_0700, 32'h0, rb, 0, 0);
    n_wr = 0;
    teardown = 1'b1;
    @(negedge core_clk);
    teardown = 1'b0;
    go(32'h0000_0600); // restart after the halt, as software does on seeing queue-end
    wait_on(2);
    repeat (10) @(negedge core_clk);
    chk(rd(32'h0000_060C), (ra & ~f_own) | f_tdn);
    chk(rd(32'h0000_070C), rb);
    chk(n_wr, 1);
    // refused starts: misaligned head, null head
    go(32'h0000_0802);
    wait_on(3);
    go(32'h0000_0000);
    repeat (5) @(negedge core_clk);
    chk({31'h0, busy}, 32'h0);
    chk(exq.size(), 0);
    end_sim();
  end
  // watchdog at 5000 cycles, far beyond the few hundred cycles the scenarios need
  initial begin
    #125000;
    n_errors++;
    end_sim();
  end
endmodule : mdfh_top_tb
